// ==== hw/dvtmr_ctrl.sv ====
`timescale 1ns/1ps
// controller end: software orders over avalon, mode register sets out
module dvtmr_ctrl #(
    parameter int MRS_GAP = dvtmr_pkg::MRS_GAP_CYCLES // cycles between sets
) (
    input wire logic core_clk, // clock
    input wire logic reset_n, // async reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // high until the answer
    dvtmr_mrs_if.ctrl mrs // command pins to dram
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_GAP = 2'b10
    } dvtmr_state_e;

    generate
        if (MRS_GAP < 2 || MRS_GAP > 65535) begin : g_bad_gap
            $error("MRS_GAP out of range");
        end
    endgenerate

    dvtmr_state_e state;
    logic [15:0] gap_count;
    logic [8:0] setup;
    logic [2:0] spacing;
    logic [17:0] raw_word;
    logic refused;
    logic req;
    logic take;
    logic cmd_wr;
    logic [2:0] cmd_sel;
    logic [1:0] cmd_step;
    logic [5:0] next_value;
    logic next_refuse;
    logic [17:0] train_word;

    assign req = avs_read || avs_write;
    assign cmd_wr = avs_write && (avs_address == dvtmr_pkg::REG_COMMAND);
    assign take = req && !avs_waitrequest;
    assign cmd_sel = avs_writedata[dvtmr_pkg::CMD_SEL_LSB +: 3];
    assign cmd_step = avs_writedata[dvtmr_pkg::CMD_STEP_LSB +: 2];

    // step the held value by one, clamped to the defined codes
    always_comb begin
        next_value = setup[5:0];
        if (cmd_step == dvtmr_pkg::STEP_UP && setup[5:0] < dvtmr_pkg::VALUE_MAX) begin
            next_value = setup[5:0] + 6'h01;
        end else if (cmd_step == dvtmr_pkg::STEP_DOWN && setup[5:0] != 6'h00) begin
            next_value = setup[5:0] - 6'h01;
        end
    end

    // training word; unused bits stay zero, enable forced by auto bit
    always_comb begin
        train_word = 18'h00000;
        train_word[dvtmr_pkg::VALUE_LSB +: dvtmr_pkg::VALUE_W] = next_value;
        train_word[dvtmr_pkg::RANGE_BIT] = setup[dvtmr_pkg::RANGE_BIT];
        train_word[dvtmr_pkg::ENABLE_BIT] = setup[dvtmr_pkg::ENABLE_BIT] ||
            setup[dvtmr_pkg::AUTO_ENABLE_BIT];
        train_word[dvtmr_pkg::SPACING_LSB +: dvtmr_pkg::SPACING_W] = spacing;
    end

    // reserved codes never leave the controller
    assign next_refuse = (cmd_sel == dvtmr_pkg::SEL_TRAIN) &&
        ((next_value > dvtmr_pkg::VALUE_MAX) || (spacing > dvtmr_pkg::SPACING_MAX));

    // answer one cycle after a request; a command stalls while busy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest && !(cmd_wr && state != ST_IDLE)) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read data staged together with the answer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                dvtmr_pkg::REG_SETUP: avs_readdata <= {23'h000000, setup};
                dvtmr_pkg::REG_SPACING: avs_readdata <= {29'h00000000, spacing};
                dvtmr_pkg::REG_RAW: avs_readdata <= {14'h0000, raw_word};
                dvtmr_pkg::REG_STATUS: avs_readdata <= {30'h00000000, refused,
                                                        state != ST_IDLE};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // software registers; a step command also updates the held value
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            setup <= dvtmr_pkg::SETUP_RESET;
            spacing <= dvtmr_pkg::SPACING_RESET;
            raw_word <= 18'h00000;
        end else if (take && avs_write) begin
            if (avs_address == dvtmr_pkg::REG_SETUP) begin
                setup <= avs_writedata[8:0];
            end else if (avs_address == dvtmr_pkg::REG_SPACING) begin
                spacing <= avs_writedata[2:0];
            end else if (avs_address == dvtmr_pkg::REG_RAW) begin
                raw_word <= avs_writedata[17:0];
            end else if (cmd_wr && !next_refuse && cmd_sel == dvtmr_pkg::SEL_TRAIN) begin
                setup[5:0] <= next_value;
            end
        end
    end

    // outcome of the last command
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            refused <= 1'b0;
        end else if (take && cmd_wr) begin
            refused <= next_refuse;
        end
    end

    // sequencer: one set on the pins, then a quiet gap
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            gap_count <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && cmd_wr && !next_refuse) begin
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state <= ST_GAP;
                    gap_count <= 16'h0000;
                end
                ST_GAP: begin
                    if (gap_count == 16'(MRS_GAP - 2)) begin
                        state <= ST_IDLE;
                    end else begin
                        gap_count <= gap_count + 16'h0001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // pins: driven while in the issue state, deselect otherwise
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mrs.cs_n <= 1'b1;
            mrs.act_n <= 1'b1;
            mrs.ras_n <= 1'b1;
            mrs.cas_n <= 1'b1;
            mrs.we_n <= 1'b1;
            mrs.bg <= 2'h0;
            mrs.ba <= 2'h0;
            mrs.addr <= 18'h00000;
        end else if (state == ST_IDLE && take && cmd_wr && !next_refuse) begin
            mrs.cs_n <= 1'b0;
            mrs.ras_n <= 1'b0;
            mrs.cas_n <= 1'b0;
            mrs.we_n <= 1'b0;
            mrs.bg <= {1'b0, cmd_sel[2]}; // bg1 unused here, held zero
            mrs.ba <= cmd_sel[1:0];
            mrs.addr <= (cmd_sel == dvtmr_pkg::SEL_TRAIN) ? train_word : raw_word;
        end else begin
            mrs.cs_n <= 1'b1;
            mrs.ras_n <= 1'b1;
            mrs.cas_n <= 1'b1;
            mrs.we_n <= 1'b1;
            mrs.addr <= 18'h00000;
        end
    end
endmodule

// ==== hw/dvtmr_dram.sv ====
`timescale 1ns/1ps
// Behaviour
// - ignore select 111, give no response
// - controller sends no reserved codes
// - controller zeroes reserved address bits
// - controller programs spacing for clock rate
// - device generates data reference internally
// - controller steps reference with repeated commands
// - controller sets training enable with value
// - bit 6 picks upper or lower span
// - fifty-one codes, 0.65% steps from base
// - accesses to ignored register change nothing
module dvtmr_dram (
    input wire logic core_clk, // device clock
    input wire logic reset_n, // async reset, active low
    dvtmr_mrs_if.dram mrs, // command pins from controller
    input wire logic [2:0] probe_select, // which stored mode word to show
    output logic train_enable, // training enable field
    output logic range_sel, // reference range field
    output logic [5:0] train_value, // reference value field
    output logic [2:0] spacing_code, // raw spacing field
    output logic [3:0] spacing_nck, // decoded spacing in clocks
    output logic spacing_valid, // spacing code is defined
    output logic [13:0] data_input_reference, // level, 0.01 percent units
    output logic reference_valid, // reference code is defined
    output logic reserved_code_seen, // last training write held reserved code
    output logic capture_pulse, // training register was just written
    output logic [7:0] ignored_count, // saturating count of ignored sets
    output logic [17:0] probe_word // stored word of probed register
);
    logic is_mrs;
    logic [2:0] sel;
    logic hit_train;
    logic hit_other;
    logic [13:0] dec_level;
    logic dec_valid;
    logic next_reserved;
    logic [17:0] mode_store [0:dvtmr_pkg::MODE_WORDS-1];
    logic hit_ignored;
    logic [17:0] train_word;

    // slices, ports and store are sized for these values
    generate
        if (dvtmr_pkg::MODE_WORDS != int'(dvtmr_pkg::SEL_TRAIN)) begin : g_bad_words
            $error("one store word per lower select");
        end
        if (dvtmr_pkg::SEL_W != 3 || dvtmr_pkg::SEL_IGNORED != 3'h7) begin : g_bad_sel
            $error("select must be three bits");
        end
        if (dvtmr_pkg::VALUE_W != 6 || dvtmr_pkg::SPACING_W != 3) begin : g_bad_fields
            $error("field widths do not match");
        end
        if (dvtmr_pkg::ADDR_W != 18 || dvtmr_pkg::LEVEL_W != 14) begin : g_bad_widths
            $error("opcode or level width wrong");
        end
        if ({1'b0, dvtmr_pkg::SPACING_BASE_NCK} + dvtmr_pkg::SPACING_MAX > 5'h0F) begin : g_nck
            $error("spacing count overflows");
        end
    endgenerate

    // command decode straight off the pins, same clock as controller
    // no flops in front: every pin is a controller flop
    assign is_mrs = !mrs.cs_n && mrs.act_n && !mrs.ras_n && !mrs.cas_n && !mrs.we_n;
    assign sel = {mrs.bg[0], mrs.ba};

    // select 111 reaches no register and raises nothing
    assign hit_train = is_mrs && (sel == dvtmr_pkg::SEL_TRAIN);
    assign hit_other = is_mrs && (sel < dvtmr_pkg::SEL_TRAIN);
    // one compare per select, so 111 feeds only the counter
    assign hit_ignored = is_mrs && (sel == dvtmr_pkg::SEL_IGNORED);

    // reserved field codes or nonzero reserved bits in the incoming word
    always_comb begin
        next_reserved = 1'b0;
        if (mrs.addr[dvtmr_pkg::VALUE_LSB +: dvtmr_pkg::VALUE_W] > dvtmr_pkg::VALUE_MAX) begin
            next_reserved = 1'b1;
        end
        if (mrs.addr[dvtmr_pkg::SPACING_LSB +: dvtmr_pkg::SPACING_W] >
            dvtmr_pkg::SPACING_MAX) begin
            next_reserved = 1'b1;
        end
        if ((mrs.addr & ~dvtmr_pkg::TRAIN_USED_MASK) != 18'h00000) begin
            next_reserved = 1'b1;
        end
    end

    // training fields, held until the next training register set
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            train_enable <= 1'b0;
            range_sel <= 1'b0;
            train_value <= 6'h00;
        end else if (hit_train) begin
            train_enable <= mrs.addr[dvtmr_pkg::ENABLE_BIT];
            range_sel <= mrs.addr[dvtmr_pkg::RANGE_BIT];
            train_value <= mrs.addr[dvtmr_pkg::VALUE_LSB +: dvtmr_pkg::VALUE_W];
        end
    end

    // spacing field shares the same register word
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            spacing_code <= 3'h0;
        end else if (hit_train) begin
            spacing_code <= mrs.addr[dvtmr_pkg::SPACING_LSB +: dvtmr_pkg::SPACING_W];
        end
    end

    // spacing decode; reserved codes keep the last defined clock count
    // a reserved code names no clock count to switch to
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            spacing_nck <= dvtmr_pkg::SPACING_BASE_NCK;
            spacing_valid <= 1'b1;
        end else begin
            spacing_valid <= (spacing_code <= dvtmr_pkg::SPACING_MAX);
            if (spacing_code <= dvtmr_pkg::SPACING_MAX) begin
                spacing_nck <= dvtmr_pkg::SPACING_BASE_NCK + {1'b0, spacing_code};
            end
        end
    end

    // reference level decoder on the held fields
    dvtmr_ref_decode u_decode (
        .range_sel(range_sel),
        .code(train_value),
        .level(dec_level),
        .valid(dec_valid)
    );

    // internal reference, one cycle behind the held fields
    // registered so the level never shows the adder settling
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_input_reference <= dvtmr_pkg::RANGE1_BASE;
            reference_valid <= 1'b1;
        end else begin
            data_input_reference <= dec_level;
            reference_valid <= dec_valid;
        end
    end

    // flags behaviour that is undefined, so a bench can see it happened
    // a level, not sticky: each training set rewrites it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reserved_code_seen <= 1'b0;
        end else if (hit_train) begin
            reserved_code_seen <= next_reserved;
        end
    end

    // one-cycle strobe per accepted training write
    // lets a checker tie every field change to one set
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_pulse <= 1'b0;
        end else begin
            capture_pulse <= hit_train;
        end
    end

    // ignored sets are counted only for observation, nothing else moves
    // saturates so a long run never wraps back to zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ignored_count <= 8'h00;
        end else if (hit_ignored && (ignored_count != 8'hFF)) begin
            ignored_count <= ignored_count + 8'h01;
        end
    end

    // other mode registers kept whole; their fields are decoded elsewhere
    // indexed by select, so 111 can never land here
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < dvtmr_pkg::MODE_WORDS; i++) begin
                mode_store[i] <= 18'h00000;
            end
        end else if (hit_other) begin
            mode_store[sel] <= mrs.addr;
        end
    end

    // training word rebuilt at its field positions, reserved bits zero
    always_comb begin
        train_word = 18'h00000;
        train_word[dvtmr_pkg::VALUE_LSB +: dvtmr_pkg::VALUE_W] = train_value;
        train_word[dvtmr_pkg::RANGE_BIT] = range_sel;
        train_word[dvtmr_pkg::ENABLE_BIT] = train_enable;
        train_word[dvtmr_pkg::SPACING_LSB +: dvtmr_pkg::SPACING_W] = spacing_code;
    end

    // probe read of the stored words; the training word is rebuilt
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            probe_word <= 18'h00000;
        end else if (probe_select < dvtmr_pkg::SEL_TRAIN) begin
            probe_word <= mode_store[probe_select];
        end else if (probe_select == dvtmr_pkg::SEL_TRAIN) begin
            probe_word <= train_word;
        end else begin
            probe_word <= 18'h00000; // nothing is stored for select 111
        end
    end
endmodule

// ==== hw/dvtmr_mrs_if.sv ====
`timescale 1ns/1ps
// command and address pins from controller to dram, one clock
interface dvtmr_mrs_if (
    input wire logic core_clk // shared command clock
);
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;

    modport dram (
        input core_clk, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr
    );
    modport ctrl (
        input core_clk,
        output cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr
    );
endinterface

// ==== hw/dvtmr_pkg.sv ====
package dvtmr_pkg;
    // command pins and mode register select
    localparam int ADDR_W = 18;
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_TRAIN = 3'h6;
    localparam logic [2:0] SEL_IGNORED = 3'h7;
    localparam int MODE_WORDS = 6;

    // reference_train_mode_register field layout
    localparam int VALUE_LSB = 0;
    localparam int VALUE_W = 6;
    localparam int RANGE_BIT = 6;
    localparam int ENABLE_BIT = 7;
    localparam int SPACING_LSB = 10;
    localparam int SPACING_W = 3;
    localparam logic [17:0] TRAIN_USED_MASK = 18'h01CFF;
    localparam logic [5:0] VALUE_MAX = 6'h32;
    localparam logic [2:0] SPACING_MAX = 3'h4;
    localparam logic [3:0] SPACING_BASE_NCK = 4'h4;

    // reference level in hundredths of a percent of output_supply_level
    localparam int LEVEL_W = 14;
    localparam logic [13:0] RANGE1_BASE = 14'h1770;
    localparam logic [13:0] RANGE2_BASE = 14'h1194;
    localparam logic [6:0] LEVEL_STEP = 7'h41;

    // controller register map, byte addresses
    localparam int AVS_ADDR_W = 8;
    localparam logic [7:0] REG_SETUP = 8'h00;
    localparam logic [7:0] REG_SPACING = 8'h04;
    localparam logic [7:0] REG_RAW = 8'h08;
    localparam logic [7:0] REG_COMMAND = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int SETUP_W = 9;
    localparam int AUTO_ENABLE_BIT = 8;
    localparam logic [8:0] SETUP_RESET = 9'h100;
    localparam logic [2:0] SPACING_RESET = 3'h0;
    localparam int CMD_SEL_LSB = 0;
    localparam int CMD_STEP_LSB = 4;
    localparam logic [1:0] STEP_UP = 2'h1;
    localparam logic [1:0] STEP_DOWN = 2'h2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;

    // cycles from one mode register set to the next
    localparam int MRS_GAP_CYCLES = 24;
endpackage

// ==== hw/dvtmr_ref_decode.sv ====
`timescale 1ns/1ps
// maps range and code to a reference level, combinational
module dvtmr_ref_decode (
    input wire logic range_sel, // 0 upper span, 1 lower span
    input wire logic [5:0] code, // training value
    output logic [13:0] level, // hundredths of a percent
    output logic valid // code within the fifty steps
);
    logic [12:0] offset;

    // base plus code times one step
    assign offset = {7'h00, code} * {6'h00, dvtmr_pkg::LEVEL_STEP};
    assign level = (range_sel ? dvtmr_pkg::RANGE2_BASE : dvtmr_pkg::RANGE1_BASE)
        + {1'b0, offset};
    assign valid = (code <= dvtmr_pkg::VALUE_MAX);
endmodule

// ==== verif/dvtmr_mrs_asserts.sv ====
`timescale 1ns/1ps
// watches the command pins and the fields the dram end captures
module dvtmr_mrs_asserts (
    input wire logic core_clk, // clock
    input wire logic reset_n, // async reset, active low
    input wire logic cs_n, // chip select
    input wire logic act_n, // activate
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write enable
    input wire logic [1:0] bg, // group select
    input wire logic [1:0] ba, // bank select
    input wire logic [17:0] addr, // opcode
    input wire logic train_enable, // enable field
    input wire logic range_sel, // range field
    input wire logic [5:0] train_value, // value field
    input wire logic [2:0] spacing_code, // spacing field
    input wire logic capture_pulse, // capture strobe
    input wire logic [7:0] ignored_count, // ignored sets
    input wire logic [13:0] data_input_reference // level
);
    logic set_cmd;
    logic sel6;
    logic sel7;
    // decoded set and its select
    assign set_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;
    assign sel6 = set_cmd && {bg[0], ba} == 3'h6;
    assign sel7 = set_cmd && {bg[0], ba} == 3'h7;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_set_single: assert property (set_cmd |=> !set_cmd)
        else $error("set held over one cycle");
    a_ignored_silent: assert property (sel7 |=> !capture_pulse)
        else $error("ignored select answered");
    a_ignored_count: assert property (sel7 && ignored_count != 8'hFF |=>
        ignored_count == $past(ignored_count) + 8'h01) else $error("ignored count wrong");
    a_ignored_fields: assert property (sel7 |=>
        $stable({train_enable, range_sel, train_value, spacing_code}))
        else $error("ignored register changed fields");
    a_fields_hold: assert property (!sel6 |=>
        $stable({train_enable, range_sel, train_value, spacing_code}))
        else $error("fields moved without set");
    a_fields_capture: assert property (sel6 |=>
        {train_enable, range_sel, train_value, spacing_code} == $past({addr[7:0], addr[12:10]}))
        else $error("fields not captured");
    a_pulse_cause: assert property (capture_pulse |-> $past(sel6))
        else $error("stray capture pulse");
    a_reference_level: assert property (capture_pulse && train_value <= 6'h32 |=>
        data_input_reference == (range_sel ? 14'h1194 : 14'h1770) + 14'(train_value) * 14'h0041)
        else $error("reference level wrong");
    a_reserved_zero: assert property (sel6 |-> (addr & ~dvtmr_pkg::TRAIN_USED_MASK) == 18'h00000)
        else $error("reserved opcode bit set");
    a_no_reserved: assert property (sel6 |-> addr[5:0] <= 6'h32 && addr[12:10] <= 3'h4)
        else $error("reserved code sent");
    a_enable_set: assert property (sel6 |-> addr[7])
        else $error("training enable not set");
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
// software orders in at the controller, fields seen at the dram end
module tb_top;
    logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address, ignored_count;
    logic [31:0] avs_writedata, avs_readdata;
    logic [2:0] probe_select, spacing_code;
    logic train_enable, range_sel, spacing_valid, reference_valid, reserved_code_seen;
    logic capture_pulse;
    logic [5:0] train_value;
    logic [3:0] spacing_nck;
    logic [13:0] data_input_reference;
    logic [17:0] probe_word;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    // level table: range, code, expected level in hundredths of a percent
    logic lv_rng [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [5:0] lv_code [6] = '{6'h00, 6'h00, 6'h32, 6'h32, 6'h0D, 6'h27};
    logic [17:0] lv_exp [6] = '{18'h01770, 18'h01194, 18'h02422, 18'h01E46, 18'h01ABD, 18'h01B7B};

    dvtmr_mrs_if dvtmr_mrs_if_inst (.core_clk);
    dvtmr_ctrl #(.MRS_GAP(8)) dvtmr_ctrl_inst (.core_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mrs(dvtmr_mrs_if_inst));
    dvtmr_dram dvtmr_dram_inst (.core_clk, .reset_n, .mrs(dvtmr_mrs_if_inst), .probe_select,
        .train_enable, .range_sel, .train_value, .spacing_code, .spacing_nck, .spacing_valid,
        .data_input_reference, .reference_valid, .reserved_code_seen, .capture_pulse,
        .ignored_count, .probe_word);
    dvtmr_mrs_asserts dvtmr_mrs_asserts_inst (.core_clk, .reset_n,
        .cs_n(dvtmr_mrs_if_inst.cs_n), .act_n(dvtmr_mrs_if_inst.act_n),
        .ras_n(dvtmr_mrs_if_inst.ras_n), .cas_n(dvtmr_mrs_if_inst.cas_n),
        .we_n(dvtmr_mrs_if_inst.we_n), .bg(dvtmr_mrs_if_inst.bg), .ba(dvtmr_mrs_if_inst.ba),
        .addr(dvtmr_mrs_if_inst.addr), .train_enable, .range_sel, .train_value, .spacing_code,
        .capture_pulse, .ignored_count, .data_input_reference);

    // 250 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t: timeout", $time);
            finish_test();
        end
    end

    task finish_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: register read %h expected %h", $time, got, exp);
        end
    endtask
    task chk_out(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: dram output %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task av(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        chk_reg(q, exp);
    endtask
    // issue a command, wait out busy, let the level settle
    task mrs(input logic [2:0] sel, input logic [1:0] step);
        logic [31:0] q;
        wr(dvtmr_pkg::REG_COMMAND, {26'h0, step, 1'b0, sel});
        do av(1'b0, dvtmr_pkg::REG_STATUS, 32'h0, q); while (q[0] !== 1'b0);
        repeat (2) @(posedge core_clk);
    endtask

    task t_reset();
        rd_chk(dvtmr_pkg::REG_SETUP, 32'h100);
        rd_chk(dvtmr_pkg::REG_SPACING, 32'h0);
        wr(8'h40, 32'hFFFF);
        rd_chk(8'h40, 32'h0);
        rd_chk(dvtmr_pkg::REG_COMMAND, 32'h0);
        chk_out(18'(data_input_reference), 18'h01770);
        chk_out(18'(spacing_nck), 18'h4);
        $display("test reset done");
    endtask
    task t_levels();
        for (int i = 0; i < 6; i++) begin
            wr(dvtmr_pkg::REG_SPACING, 32'(i % 5));
            wr(dvtmr_pkg::REG_SETUP, {23'h0, 2'b10, lv_rng[i], lv_code[i]});
            mrs(3'h6, 2'h0);
            chk_out(18'(train_value), 18'(lv_code[i]));
            chk_out(18'(range_sel), 18'(lv_rng[i]));
            chk_out(18'(train_enable), 18'h1);
            chk_out(18'(data_input_reference), lv_exp[i]);
            chk_out(18'({reference_valid, spacing_valid}), 18'h3);
            chk_out(18'(reserved_code_seen), 18'h0);
            chk_out(18'(spacing_nck), 18'(4 + i % 5));
        end
        $display("test levels done");
    endtask
    task t_step();
        wr(dvtmr_pkg::REG_SETUP, 32'h131);
        mrs(3'h6, dvtmr_pkg::STEP_UP);
        mrs(3'h6, dvtmr_pkg::STEP_UP);
        chk_out(18'(train_value), 18'h32);
        mrs(3'h6, dvtmr_pkg::STEP_DOWN);
        chk_out(18'(train_value), 18'h31);
        chk_out(18'(data_input_reference), 18'h023E1);
        rd_chk(dvtmr_pkg::REG_SETUP, 32'h131);
        rd_chk(dvtmr_pkg::REG_STATUS, 32'h0);
        $display("test step done");
    endtask
    task t_refused();
        wr(dvtmr_pkg::REG_SETUP, 32'h133);
        mrs(3'h6, 2'h0);
        chk_out(18'(train_value), 18'h31);
        rd_chk(dvtmr_pkg::REG_STATUS, 32'h2);
        wr(dvtmr_pkg::REG_SPACING, 32'h5);
        wr(dvtmr_pkg::REG_SETUP, 32'h100);
        mrs(3'h6, 2'h0);
        chk_out(18'(train_value), 18'h31);
        rd_chk(dvtmr_pkg::REG_STATUS, 32'h2);
        wr(dvtmr_pkg::REG_SPACING, 32'h2);
        mrs(3'h6, 2'h0);
        chk_out(18'({spacing_nck, train_value}), 18'h180);
        rd_chk(dvtmr_pkg::REG_STATUS, 32'h0);
        $display("test refused done");
    endtask
    task t_ignored();
        logic [7:0] cnt;
        cnt = ignored_count;
        wr(dvtmr_pkg::REG_RAW, 32'h3FFFF);
        mrs(3'h7, 2'h0);
        chk_out(18'(ignored_count), 18'(cnt + 8'h01));
        chk_out(18'({train_enable, range_sel, spacing_code, train_value}), 18'h480);
        wr(dvtmr_pkg::REG_RAW, 32'h00155);
        mrs(3'h3, 2'h0);
        probe_select <= 3'h3;
        repeat (2) @(posedge core_clk);
        chk_out(probe_word, 18'h00155);
        chk_out(18'({train_enable, range_sel, spacing_code, train_value}), 18'h480);
        $display("test ignored done");
    endtask

    // reset, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        probe_select = 3'h0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_levels();
        t_step();
        t_refused();
        t_ignored();
        finish_test();
    end
endmodule
